/* File: hdl/pid_reg_pkg.sv */
// Constants and carrier types for the process regulator
package pid_reg_pkg;

  // ********************
  // Timing
  // ********************
  localparam int CLK_PERIOD_NS  = 8;
  localparam int TICK_PERIOD_NS = 2_000_000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS        = 2;
  localparam int HOLD_UNIT_MS   = 10;
  localparam int HOLD_TICKS     = HOLD_UNIT_MS / TICK_MS;
  localparam int LOSS_UNIT_MS   = 100;
  localparam int LOSS_TICKS     = LOSS_UNIT_MS / TICK_MS;

  // ********************
  // Scaling: in 0.1 %, out 0.01 %
  // ********************
  localparam int FULL_OUT   = 10000;
  localparam int OUT_PER_IN = 10;
  localparam int KP_DIV     = 100;
  localparam int I_SCALE    = 1000;
  localparam int I_NUM = OUT_PER_IN * I_SCALE * TICK_MS / HOLD_UNIT_MS;
  localparam int D_NUM = OUT_PER_IN / TICK_MS;
  localparam logic [7:0] DIGIT_BASE = 8'h0A;
  localparam logic [7:0] DIGIT_ON   = 8'h01;

  // ********************
  // Register map
  // ********************
  localparam int CFG_N = 10;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_KP     = 8'h08;
  localparam logic [7:0] ADDR_TI     = 8'h0C;
  localparam logic [7:0] ADDR_TD     = 8'h10;
  localparam logic [7:0] ADDR_MODE   = 8'h14;
  localparam logic [7:0] ADDR_THR    = 8'h18;
  localparam logic [7:0] ADDR_START  = 8'h1C;
  localparam logic [7:0] ADDR_LOSS   = 8'h20;
  localparam logic [7:0] ADDR_STEP   = 8'h24;
  localparam logic [7:0] ADDR_END    = 8'h28;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam int MODE_DB_LSB    = 0;
  localparam int MODE_DIR_BIT   = 16;
  localparam int MODE_GSW_LSB   = 20;
  localparam int MODE_IPROP_LSB = 24;
  localparam int ST_FAULT_BIT   = 0;
  localparam int ST_HOLD_BIT    = 1;
  localparam int ST_DB_BIT      = 2;
  localparam int ST_OUT_LSB     = 16;
  localparam logic [31:0] RST_KP   = 32'h00C8_00C8;
  localparam logic [31:0] RST_TI   = 32'h00C8_00C8;
  localparam logic [31:0] RST_THR  = 32'h0320_00C8;
  localparam logic [31:0] RST_STEP = 32'h0064_0064;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] CFG_RST [CFG_N] = '{RST_ZERO, RST_ZERO,
    RST_KP, RST_TI, RST_ZERO, RST_ZERO, RST_THR, RST_ZERO, RST_ZERO,
    RST_STEP};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    GSW_NONE = 2'h0,
    GSW_TERM = 2'h1,
    GSW_AUTO = 2'h2
  } gsw_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic pause;
    logic dir_inv;
    logic gain_sel;
  } din_t;

endpackage

/* File: hdl/process_pid_regulator.sv */
// Process regulator with register slave, gain switching, loss check
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module process_pid_regulator #(
  parameter int TICK_CYC = pid_reg_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // Register bus
  input  wire pid_reg_pkg::axil_req_t i_axi,
  output      pid_reg_pkg::axil_rsp_t o_axi,
  // Process channels, 0.1 % steps
  input  wire logic [15:0]            i_setting,
  input  wire logic [15:0]            i_feedback,
  // Digital input terminals
  input  wire pid_reg_pkg::din_t      i_din,
  // Regulator results
  output      logic signed [15:0]     o_freq_corr,
  output      logic                   o_update,
  output      logic                   o_fb_loss_fault
);
  import pid_reg_pkg::*;

  typedef logic signed [31:0] s32_t;

  function automatic s32_t ext(input logic [15:0] v);
    return $signed({16'h0000, v});
  endfunction

  function automatic s32_t clamp(input s32_t v, input s32_t m);
    if (v > m) return m;
    if (v < -m) return -m;
    return v;
  endfunction

  function automatic logic hit(input logic [7:0] a);
    if (a[1:0] != 2'h0) return 1'b0;
    else if (a >= ADDR_END) return 1'b0;
    else return 1'b1;
  endfunction

  function automatic s32_t gain_pick(input logic [15:0] g1,
      input logic [15:0] g2, input logic [1:0] md, input logic sel,
      input s32_t a, input logic [15:0] lo, input logic [15:0] hi);
    s32_t s1;
    s32_t s2;
    s1 = ext(g1);
    s2 = ext(g2);
    if (md == GSW_TERM) return sel ? s2 : s1;
    if (md != GSW_AUTO || a <= ext(lo)) return s1;
    if (a >= ext(hi)) return s2;
    return s1 + (s2 - s1) * (a - ext(lo)) / (ext(hi) - ext(lo));
  endfunction

  // ********************
  // Register bus
  // ********************
  logic [31:0] cfg_ff [CFG_N];
  axil_rsp_t   rsp_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [7:0]  awa_ff;
  logic [31:0] wd_ff;
  logic [3:0]  ws_ff;
  logic [31:0] status_w;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rsp_ff    <= '0;
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awa_ff    <= 8'h00;
      wd_ff     <= 32'h0000_0000;
      ws_ff     <= 4'h0;
      for (int k = 0; k < CFG_N; k++) cfg_ff[k] <= CFG_RST[k];
    end else begin
      rsp_ff.awready <= i_axi.awvalid && !rsp_ff.awready &&
                        !aw_got_ff && !rsp_ff.bvalid;
      rsp_ff.wready  <= i_axi.wvalid && !rsp_ff.wready &&
                        !w_got_ff && !rsp_ff.bvalid;
      if (i_axi.awvalid && rsp_ff.awready) begin
        aw_got_ff <= 1'b1;
        awa_ff    <= i_axi.awaddr;
      end
      if (i_axi.wvalid && rsp_ff.wready) begin
        w_got_ff <= 1'b1;
        wd_ff    <= i_axi.wdata;
        ws_ff    <= i_axi.wstrb;
      end
      // Fault clear strobe lasts one cycle
      cfg_ff[ADDR_CTRL[5:2]][CTRL_CLR_BIT] <= 1'b0;
      if (aw_got_ff && w_got_ff && !rsp_ff.bvalid) begin
        aw_got_ff     <= 1'b0;
        w_got_ff      <= 1'b0;
        rsp_ff.bvalid <= 1'b1;
        rsp_ff.bresp  <= hit(awa_ff) ? RESP_OKAY : RESP_SLVERR;
        if (hit(awa_ff) && awa_ff != ADDR_STATUS) begin
          for (int b = 0; b < 4; b++) begin
            if (ws_ff[b]) begin
              cfg_ff[awa_ff[5:2]][8*b+:8] <= wd_ff[8*b+:8];
            end
          end
        end
      end else if (rsp_ff.bvalid && i_axi.bready) begin
        rsp_ff.bvalid <= 1'b0;
      end
      rsp_ff.arready <= i_axi.arvalid && !rsp_ff.arready &&
                        !rsp_ff.rvalid;
      if (i_axi.arvalid && rsp_ff.arready) begin
        rsp_ff.rvalid <= 1'b1;
        rsp_ff.rresp  <= hit(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
        if (!hit(i_axi.araddr)) rsp_ff.rdata <= 32'h0000_0000;
        else if (i_axi.araddr == ADDR_STATUS) rsp_ff.rdata <= status_w;
        else rsp_ff.rdata <= cfg_ff[i_axi.araddr[5:2]];
      end else if (rsp_ff.rvalid && i_axi.rready) begin
        rsp_ff.rvalid <= 1'b0;
      end
    end
  end

  assign o_axi = rsp_ff;

  // ********************
  // Configuration fields
  // ********************
  logic [15:0] kp1, kp2, ti1, ti2, td1, td2, dband, thr_lo, thr_hi;
  logic [15:0] init_v, hold_t, loss_lv, loss_t, step_f, step_r;
  logic [1:0]  gsw;
  logic [7:0]  iprop;
  logic        dir_cfg, run, clr;

  assign {kp2, kp1}         = cfg_ff[ADDR_KP[5:2]];
  assign {ti2, ti1}         = cfg_ff[ADDR_TI[5:2]];
  assign {td2, td1}         = cfg_ff[ADDR_TD[5:2]];
  assign {thr_hi, thr_lo}   = cfg_ff[ADDR_THR[5:2]];
  assign {hold_t, init_v}   = cfg_ff[ADDR_START[5:2]];
  assign {loss_t, loss_lv}  = cfg_ff[ADDR_LOSS[5:2]];
  assign {step_r, step_f}   = cfg_ff[ADDR_STEP[5:2]];
  assign dband   = cfg_ff[ADDR_MODE[5:2]][MODE_DB_LSB+:16];
  assign dir_cfg = cfg_ff[ADDR_MODE[5:2]][MODE_DIR_BIT];
  assign gsw     = cfg_ff[ADDR_MODE[5:2]][MODE_GSW_LSB+:2];
  assign iprop   = cfg_ff[ADDR_MODE[5:2]][MODE_IPROP_LSB+:8];
  assign run     = cfg_ff[ADDR_CTRL[5:2]][CTRL_RUN_BIT];
  assign clr     = cfg_ff[ADDR_CTRL[5:2]][CTRL_CLR_BIT];

  // ********************
  // Terminal synchroniser and tick
  // ********************
  din_t        din_s1_ff;
  din_t        din_s2_ff;
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
    end else begin
      din_s1_ff <= i_din;
      din_s2_ff <= din_s1_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // ********************
  // Regulator arithmetic
  // ********************
  logic signed [15:0] out_ff;
  s32_t        acc_ff;
  logic [15:0] fbp_ff;
  logic        run_d_ff, holding_ff, db_ff, upd_ff;
  logic [31:0] hcnt_ff;
  logic [31:0] hold_total;
  s32_t err, aerr, gp, gi, gd, sdelta, i_inc, acc_nxt, lim, diff;
  s32_t init_out, nxt_out;
  logic dir_eff, in_db, integ_on, at_lim, reg_go, units_on, tens_on;

  always_comb begin
    dir_eff  = dir_cfg ^ din_s2_ff.dir_inv;
    err      = dir_eff ? ext(i_feedback) - ext(i_setting)
                       : ext(i_setting) - ext(i_feedback);
    aerr     = (err < 0) ? -err : err;
    in_db    = aerr < ext(dband);
    gp = gain_pick(kp1, kp2, gsw, din_s2_ff.gain_sel, aerr, thr_lo, thr_hi);
    gi = gain_pick(ti1, ti2, gsw, din_s2_ff.gain_sel, aerr, thr_lo, thr_hi);
    gd = gain_pick(td1, td2, gsw, din_s2_ff.gain_sel, aerr, thr_lo, thr_hi);
    if (gi < 1) gi = 1;
    units_on = (iprop % DIGIT_BASE) == DIGIT_ON;
    tens_on  = ((iprop / DIGIT_BASE) % DIGIT_BASE) == DIGIT_ON;
    at_lim   = (s32_t'(out_ff) >= FULL_OUT) || (s32_t'(out_ff) <= -FULL_OUT);
    integ_on = !(units_on && din_s2_ff.pause)
               && !(tens_on && at_lim);
    i_inc    = err * I_NUM / gi;
    acc_nxt  = clamp(acc_ff + (integ_on ? i_inc : 0), FULL_OUT * I_SCALE);
    sdelta   = ext(i_feedback) - ext(fbp_ff);
    if (!dir_eff) sdelta = -sdelta;
    lim = clamp(gp * err / KP_DIV
                + acc_nxt / I_SCALE
                + sdelta * gd * D_NUM, FULL_OUT);
    diff = lim - s32_t'(out_ff);
    if (diff > ext(step_f)) nxt_out = s32_t'(out_ff) + ext(step_f);
    else if (diff < -ext(step_r)) nxt_out = s32_t'(out_ff) - ext(step_r);
    else nxt_out = lim;
    init_out   = clamp(ext(init_v) * OUT_PER_IN, FULL_OUT);
    hold_total = 32'(hold_t) * 32'(HOLD_TICKS);
    reg_go     = run && run_d_ff && !(holding_ff && hcnt_ff < hold_total);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      out_ff     <= 16'sh0000;
      acc_ff     <= 32'sh0000_0000;
      fbp_ff     <= 16'h0000;
      run_d_ff   <= 1'b0;
      holding_ff <= 1'b0;
      hcnt_ff    <= 32'h0000_0000;
      db_ff      <= 1'b0;
      upd_ff     <= 1'b0;
    end else begin
      upd_ff <= tick_ff;
      if (tick_ff) begin
        run_d_ff <= run;
        fbp_ff   <= i_feedback;
        if (!run) begin
          out_ff     <= 16'sh0000;
          acc_ff     <= 32'sh0000_0000;
          holding_ff <= 1'b0;
        end else if (!run_d_ff) begin
          out_ff     <= 16'(init_out);
          acc_ff     <= init_out * I_SCALE;
          holding_ff <= 1'b1;
          hcnt_ff    <= 32'h0000_0001;
        end else if (!reg_go) begin
          out_ff  <= 16'(init_out);
          acc_ff  <= init_out * I_SCALE;
          hcnt_ff <= hcnt_ff + 32'h0000_0001;
        end else begin
          holding_ff <= 1'b0;
          db_ff      <= in_db;
          if (!in_db) begin
            out_ff <= 16'(nxt_out);
            acc_ff <= acc_nxt;
          end
        end
      end
    end
  end

  assign o_freq_corr = out_ff;
  assign o_update    = upd_ff;

  // ********************
  // Feedback loss detection
  // ********************
  logic [31:0] loss_cnt_ff;
  logic [31:0] loss_total;
  logic        fault_ff;
  logic        loss_low;

  assign loss_total = 32'(loss_t) * 32'(LOSS_TICKS);
  assign loss_low   = (loss_lv != 16'h0000) && (i_feedback < loss_lv);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      loss_cnt_ff <= 32'h0000_0000;
      fault_ff    <= 1'b0;
    end else begin
      if (tick_ff && !loss_low) begin
        loss_cnt_ff <= 32'h0000_0000;
      end else if (tick_ff && loss_cnt_ff != 32'hFFFF_FFFF) begin
        loss_cnt_ff <= loss_cnt_ff + 32'h0000_0001;
      end
      if (tick_ff && loss_low && loss_cnt_ff >= loss_total) begin
        fault_ff <= 1'b1;
      end else if (clr) begin
        fault_ff <= 1'b0;
      end
    end
  end

  assign o_fb_loss_fault = fault_ff;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_FAULT_BIT] = fault_ff;
    status_w[ST_HOLD_BIT]  = holding_ff;
    status_w[ST_DB_BIT]    = db_ff;
    status_w[ST_OUT_LSB+:16] = out_ff;
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_loss_off: assert property (
    (loss_lv == 16'h0000 && !fault_ff) |=> !fault_ff
  ) else $error("loss fault set while checking disabled");
  a_loss_restart: assert property (
    (tick_ff && i_feedback >= loss_lv) |=> loss_cnt_ff == 32'h0000_0000
  ) else $error("loss timer not restarted");
  a_loss_fire: assert property (
    (tick_ff && loss_low && loss_cnt_ff >= loss_total) |=> fault_ff
  ) else $error("loss fault missing");
  a_dead_band: assert property (
    (tick_ff && reg_go && in_db) |=> $stable(out_ff) && $stable(acc_ff)
  ) else $error("output moved inside dead band");
  a_start_init: assert property (
    (tick_ff && run && !run_d_ff) |=> out_ff == 16'($past(init_out))
  ) else $error("start value not forced");
  a_step_limit: assert property (
    (tick_ff && reg_go) |=>
      s32_t'(out_ff) - s32_t'($past(out_ff)) <= ext($past(step_f))
  ) else $error("forward step exceeded");
  a_integ_pause: assert property (
    (tick_ff && reg_go && !in_db && units_on && din_s2_ff.pause)
      |=> $stable(acc_ff)
  ) else $error("integrator moved during pause");
  a_anti_windup: assert property (
    (tick_ff && reg_go && !in_db && tens_on && at_lim) |=> $stable(acc_ff)
  ) else $error("integrator moved at limit");
  a_dir_sense: assert property (
    (i_setting > i_feedback) |-> ((err > 0) == (dir_cfg == din_s2_ff.dir_inv))
  ) else $error("action direction wrong");
  a_gain_fixed: assert property (
    (gsw == GSW_NONE) |-> gp == ext(kp1)
  ) else $error("gain set 1 not used");
  a_gain_term: assert property (
    (gsw == GSW_TERM) |-> gp == ext(din_s2_ff.gain_sel ? kp2 : kp1)
  ) else $error("terminal gain select wrong");
  a_tick_pulse: assert property (
    tick_ff |=> !tick_ff ##0 upd_ff
  ) else $error("update tick not a single pulse");

  c_fault: cover property ($rose(fault_ff));
  c_hold_end: cover property ($fell(holding_ff));
  c_dead: cover property (tick_ff && reg_go && in_db);
  c_interp: cover property (gsw == GSW_AUTO && aerr > ext(thr_lo)
                            && aerr < ext(thr_hi));

endmodule

/* File: sim/proc_io_model.sv */
// Model of the process channels and digital input terminals
`timescale 1ns/1ps
module proc_io_model (
  // Clock
  input  wire logic              i_clk,
  // Targets from the bench
  input  wire logic [15:0]       i_sp,
  input  wire logic [15:0]       i_fb,
  input  wire logic [2:0]        i_dn,
  // Towards the regulator
  output      logic [15:0]       o_setting,
  output      logic [15:0]       o_feedback,
  output      pid_reg_pkg::din_t o_din
);
  import pid_reg_pkg::*;
  logic [34:0] chan_ff = '0;
  // Terminals and channels change one edge after the bench asks
  always @(posedge i_clk) begin
    chan_ff <= {i_sp, i_fb, i_dn};
  end
  assign o_setting  = chan_ff[34:19];
  assign o_feedback = chan_ff[18:3];
  assign o_din      = din_t'(chan_ff[2:0]);
endmodule

/* File: sim/process_pid_regulator_tb_top.sv */
// Self-checking bench for the process regulator
`timescale 1ns/1ps
module process_pid_regulator_tb_top;
  import pid_reg_pkg::*;
  localparam int TK = 8;
  localparam int LIMIT = 30000;
  localparam logic [31:0] KPA = 32'h03E8_03E8;
  localparam logic [31:0] KP1 = 32'h0000_03E8;
  localparam logic [31:0] TIL = 32'h03E8_03E8;
  typedef struct {
    logic [31:0] md, kp, ti;
    logic [15:0] sp, fb;
    logic [2:0]  dn;
    int          lo, hi;
  } tc_t;
  logic               i_clk = 1'b0;
  logic               i_rstn = 1'b0;
  axil_req_t          rq = '0;
  axil_rsp_t          o_axi;
  logic [15:0]        sp = 16'h0000;
  logic [15:0]        fb = 16'h0000;
  logic [2:0]         dn = 3'h0;
  logic [15:0]        setting;
  logic [15:0]        feedback;
  din_t               din;
  logic signed [15:0] corr;
  logic signed [15:0] prev = '0;
  logic               upd;
  logic               fault;
  logic               mon_on = 1'b0;
  logic [31:0]        rd_d;
  logic [1:0]         rd_r;
  int                 lim = 100;
  int                 dlt;
  int                 err_count = 0;
  int                 checked = 0;
  int                 cyc = 0;
  tc_t                tc [15];

  always #4 i_clk = ~i_clk;

  process_pid_regulator #(.TICK_CYC(TK)) dut (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_axi(rq), .o_axi(o_axi), .i_setting(setting),
    .i_feedback(feedback), .i_din(din), .o_freq_corr(corr),
    .o_update(upd), .o_fb_loss_fault(fault));
  proc_io_model pio (.i_clk(i_clk), .i_sp(sp), .i_fb(fb), .i_dn(dn),
    .o_setting(setting), .o_feedback(feedback), .o_din(din));

  // ********************
  // Checks
  // ********************
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic rng(input string nm, input int lo, input int hi);
    logic ok;
    ok = (corr >= lo) && (corr <= hi);
    checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, corr);
    end
  endtask

  // Output moves at most one step per update
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (upd === 1'b1) begin
      dlt = int'(corr) - int'(prev);
      prev <= corr;
      if (mon_on && (dlt > lim || dlt < -lim)) begin
        err_count++;
        $display("[ERR] step exp %0d got %0d", lim, dlt);
      end
    end
    if (cyc == LIMIT) begin
      err_count++;
      give_verdict();
    end
  end

  // ********************
  // Bus and sequencing
  // ********************
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge i_clk);
    rq.awaddr <= a;
    rq.wdata <= d;
    rq.wstrb <= 4'hF;
    rq.awvalid <= 1'b1;
    rq.wvalid <= 1'b1;
    rq.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (!aw && o_axi.awready === 1'b1) begin
        aw = 1'b1;
        rq.awvalid <= 1'b0;
      end
      if (!w && o_axi.wready === 1'b1) begin
        w = 1'b1;
        rq.wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_axi.bvalid !== 1'b1);
    rq.bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, o_axi.bresp});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    rq.araddr <= a;
    rq.arvalid <= 1'b1;
    rq.rready <= 1'b1;
    do @(posedge i_clk); while (o_axi.arready !== 1'b1);
    rq.arvalid <= 1'b0;
    do @(posedge i_clk); while (o_axi.rvalid !== 1'b1);
    rq.rready <= 1'b0;
    rd_d = o_axi.rdata;
    rd_r = o_axi.rresp;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex,
                     input logic [1:0] er);
    rd(a);
    chk("rdata", ex, rd_d);
    chk("rresp", {30'h0, er}, {30'h0, rd_r});
  endtask

  task automatic tk(input int n);
    repeat (n) do @(posedge i_clk); while (upd !== 1'b1);
  endtask

  // Stop, configure, start again from the initial value
  task automatic go(input logic [31:0] md, kp, ti);
    mon_on = 1'b0;
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (3 * TK) @(posedge i_clk);
    wr(ADDR_MODE, md, RESP_OKAY);
    wr(ADDR_KP, kp, RESP_OKAY);
    wr(ADDR_TI, ti, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    mon_on = 1'b1;
  endtask

  initial begin
    tc = '{
      '{32'h0, KPA, TIL, 16'h0258, 16'h0190, 3'h0, 2000, 2100},
      '{32'h0001_0000, KPA, TIL, 16'h0258, 16'h0190, 3'h0, -2100, -2000},
      '{32'h0, KPA, TIL, 16'h0258, 16'h0190, 3'h2, -2100, -2000},
      '{32'h0001_0000, KPA, TIL, 16'h0258, 16'h0190, 3'h2, 2000, 2100},
      '{32'h0000_012C, KPA, TIL, 16'h0258, 16'h0190, 3'h0, 0, 0},
      '{32'h0000_00C8, KPA, TIL, 16'h0258, 16'h0190, 3'h0, 2000, 2100},
      '{32'h0, KP1, TIL, 16'h0258, 16'h0190, 3'h1, 2000, 2100},
      '{32'h0030_0000, KP1, TIL, 16'h0258, 16'h0190, 3'h1, 2000, 2100},
      '{32'h0010_0000, KP1, TIL, 16'h0258, 16'h0190, 3'h1, 0, 50},
      '{32'h0010_0000, KP1, TIL, 16'h0258, 16'h0190, 3'h0, 2000, 2100},
      '{32'h0020_0000, KP1, TIL, 16'h01F4, 16'h0190, 3'h1, 1000, 1050},
      '{32'h0020_0000, KP1, TIL, 16'h0384, 16'h0000, 3'h0, 0, 120},
      '{32'h0020_0000, KP1, TIL, 16'h01F4, 16'h0000, 3'h0, 2500, 2600},
      '{32'h0100_0000, 32'h0, RST_TI, 16'h0258, 16'h0190, 3'h4, 0, 0},
      '{32'h0, 32'h0, RST_TI, 16'h0258, 16'h0190, 3'h4, 40, 100}
    };
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    chk("corr", 32'h0, {16'h0, corr});
    for (int i = 0; i < CFG_N; i++) rdc(8'(4 * i), CFG_RST[i], RESP_OKAY);
    rdc(ADDR_END, 32'h0, RESP_SLVERR);
    rdc(8'h06, 32'h0, RESP_SLVERR);
    wr(ADDR_END, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
    for (int i = 0; i < 15; i++) begin
      sp <= tc[i].sp;
      fb <= tc[i].fb;
      dn <= tc[i].dn;
      go(tc[i].md, tc[i].kp, tc[i].ti);
      tk(40);
      rng("corr", tc[i].lo, tc[i].hi);
    end
    sp <= 16'h03E8;
    fb <= 16'h0000;
    dn <= 3'h0;
    lim = 10000;
    wr(ADDR_STEP, 32'h2710_2710, RESP_OKAY);
    go(32'h0, 32'h0, 32'h0001_0001);
    tk(10);
    chk("sat", 32'h2710, {16'h0, corr});
    sp <= 16'h01F4;
    wr(ADDR_START, 32'h0002_01F4, RESP_OKAY);
    go(32'h0, KPA, 32'h0001_0001);
    tk(4);
    chk("init", 32'h1388, {16'h0, corr});
    rd(ADDR_STATUS);
    chk("hold", 32'h1, {31'h0, rd_d[ST_HOLD_BIT]});
    tk(16);
    chk("after", 32'h2710, {16'h0, corr});
    wr(ADDR_START, 32'h0, RESP_OKAY);
    wr(ADDR_STEP, RST_STEP, RESP_OKAY);
    lim = 100;
    fb <= 16'h0032;
    go(32'h0, RST_KP, RST_TI);
    wr(ADDR_LOSS, 32'h0001_0064, RESP_OKAY);
    tk(45);
    chk("fault", 32'h0, {31'h0, fault});
    tk(15);
    chk("fault", 32'h1, {31'h0, fault});
    rd(ADDR_STATUS);
    chk("stflt", 32'h1, {31'h0, rd_d[ST_FAULT_BIT]});
    fb <= 16'h00C8;
    tk(2);
    wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    tk(2);
    chk("clear", 32'h0, {31'h0, fault});
    fb <= 16'h0032;
    tk(30);
    fb <= 16'h00C8;
    tk(2);
    fb <= 16'h0032;
    tk(30);
    chk("broken", 32'h0, {31'h0, fault});
    wr(ADDR_LOSS, 32'h0001_0000, RESP_OKAY);
    fb <= 16'h0000;
    tk(70);
    chk("off", 32'h0, {31'h0, fault});
    wr(ADDR_LOSS, 32'h0001_0064, RESP_OKAY);
    tk(60);
    chk("fault", 32'h1, {31'h0, fault});
    mon_on = 1'b0;
    i_rstn <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    chk("rfault", 32'h0, {31'h0, fault});
    chk("rcorr", 32'h0, {16'h0, corr});
    rdc(ADDR_LOSS, 32'h0, RESP_OKAY);
    give_verdict();
  end
endmodule
